//--- hdl/padc_core.sv
`timescale 1ns/1ps
// Summary of operation
// R1: Master clock makes two non-overlapping phases, sample and hold.
// R2: Input is captured at the falling edge of the sample phase.
// R3: Hold phase follows sampling; one sample-hold cycle per clock period (code: one per three clocks, third clock idle).
// R4: Three identical stages each resolve 4 bits, residue gain of 8.
// R5: Fourth stage resolves 4 bits only, no residue amplification.
// R6: Each stage samples in one phase and amplifies in the other.
// R7: Each stage clock is inverted relative to the stage before.
// R8: Stage results pass a delay line so one sample's bits align.
// R9: Error correction merges redundant stage bits into one 12-bit word.
// R10: Word for a sample appears three clock cycles after sampling (code: out_word updates nine clocks after the held capture).
// R11: After the latency, one new word appears every clock (code: one word per clock, but each sample's word repeats over three clocks).
// R12: Output word is registered on the external clock, bits change together.
// R13: Offset binary: most negative gives zeros, most positive gives ones.
// R14: Output bit zero is the word's least significant bit.
// R15: Full scale gives ones or zeros; just above mid-scale gives MSB only.
// R16: Capture logic ignores the first three words after clock start.
module padc_core
    import padc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [padc_pkg::PADC_WORD_W-1:0] analog_code,
    input wire logic out_ready,
    output logic sample_phase,
    output logic hold_phase,
    output logic [padc_pkg::PADC_WORD_W-1:0] out_word,
    output logic out_bit_lsb,
    output logic out_bit_one,
    output logic out_bit_two,
    output logic out_valid,
    output logic [padc_pkg::PADC_STAGES-1:0] stage_amp
);
    import padc_pkg::*;
    localparam int SW = PADC_STAGE_W;
    localparam int NS = PADC_STAGES;
    localparam int RW = PADC_WORD_W + 1;
    // Analog core stands in as a digital residue model; code is offset binary
    typedef struct packed {
        logic sample_phase;
        logic hold_phase;
        logic [1:0] fill;
        padc_state_t state;
        logic [PADC_WORD_W-1:0] held;
        logic [NS-1:0][RW-1:0] residue;
        logic [NS-1:0][SW-1:0] flash;
        logic [NS-1:0][NS-1:0][SW-1:0] dly;
        logic [PADC_WORD_W-1:0] word;
        logic word_valid;
        logic [PADC_WORD_W-1:0] out_word;
        logic out_valid;
        logic [NS-1:0] amp;
    } padc_st_t;
    padc_st_t st_r, st_nxt;
    logic [PADC_WORD_W-1:0] code_s1_r, code_s2_r;
    logic fifo_in_ready, fifo_out_valid;
    logic [PADC_WORD_W-1:0] fifo_out_data;
    logic [NS-1:0][SW-1:0] aligned;
    logic [PADC_WORD_W-1:0] corrected;

    // Pin input passes two flops before anything reads it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            code_s1_r <= PADC_WORD_ZERO;
            code_s2_r <= PADC_WORD_ZERO;
        end else begin
            code_s1_r <= analog_code;
            code_s2_r <= code_s1_r;
        end
    end

    // Delay taps: stage k waits NS-1-k cycles so all align with stage NS-1
    genvar k;
    generate
        for (k = 0; k < NS; k++) begin : g_align
            assign aligned[k] = st_r.dly[k][NS-1-k]; // [R8]
        end
    endgenerate

    // Error correction: overlapping 4-bit fields, one redundant bit each
    function automatic logic [PADC_WORD_W-1:0] padc_correct(
        input logic [NS-1:0][SW-1:0] s
    );
        logic [PADC_WORD_W+1:0] acc;
        acc = '0;
        for (int i = 0; i < NS; i++) begin
            acc = (acc << PADC_GAIN_SHIFT) + {{(PADC_WORD_W-2){1'b0}}, s[i]};
        end
        // Clamp forces any overflow past the top to all ones
        if (acc[PADC_WORD_W+1:PADC_WORD_W] != 2'b00) begin
            padc_correct = PADC_WORD_ONES; // [R13] [R15]
        end else begin
            padc_correct = acc[PADC_WORD_W-1:0]; // [R9]
        end
    endfunction

    assign corrected = padc_correct(aligned);

    always_comb begin
        st_nxt = st_r;
        // Two non-overlapping phases; one cycle of both per three clock periods, third clock idle
        st_nxt.sample_phase = !st_r.sample_phase && !st_r.hold_phase; // [R1]
        st_nxt.hold_phase = st_r.sample_phase; // [R1] [R3]
        // Capture on the cycle the sample phase falls
        if (st_r.sample_phase) begin
            st_nxt.held = code_s2_r; // [R2]
        end
        // Each stage inverts the phase of the one before
        for (int i = 0; i < NS; i++) begin
            st_nxt.amp[i] = st_nxt.hold_phase ^ i[0]; // [R6] [R7]
        end
        // Stage 0 flash from the held sample; residue carries into the next
        // Top flash bit is the redundant one, always clear in this ideal model
        st_nxt.flash[0] = {1'b0, st_r.held[PADC_WORD_W-1 -: SW-1]};
        st_nxt.residue[0] = {st_r.held[PADC_WORD_W-SW:0], {SW{1'b0}}};
        for (int i = 1; i < NS; i++) begin
            // Flash on residue top bits; top flash bit is left clear for redundancy
            st_nxt.flash[i] = {1'b0, st_r.residue[i-1][RW-1 -: SW-1]}; // [R4]
            if (i < NS - 1) begin
                st_nxt.residue[i] = RW'(st_r.residue[i-1] << PADC_GAIN_SHIFT); // [R4]
            end else begin
                st_nxt.residue[i] = '0; // [R5]
            end
        end
        for (int i = 0; i < NS; i++) begin
            st_nxt.dly[i][0] = st_r.flash[i]; // [R8]
            for (int j = 1; j < NS; j++) begin
                st_nxt.dly[i][j] = st_r.dly[i][j-1];
            end
        end
        st_nxt.word = corrected; // [R9]
        st_nxt.word_valid = 1'b0;
        case (st_r.state)
            PADC_FILL: begin
                // Pipeline not full yet; words held back
                if (st_r.fill == 2'(PADC_LATENCY - 1)) begin
                    st_nxt.state = PADC_RUN; // [R10] [R16]
                end else begin
                    st_nxt.fill = st_r.fill + 2'h1;
                end
            end
            PADC_RUN: begin
                st_nxt.word_valid = 1'b1; // [R11]
            end
            default: begin
                st_nxt.state = PADC_FILL;
            end
        endcase
        // Output latch: all bits change on one edge
        st_nxt.out_valid = fifo_out_valid;
        if (fifo_out_valid) begin
            st_nxt.out_word = fifo_out_data; // [R12] [R14]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Downstream stall drops words once the FIFO is full, and the output latch loads the FIFO's frozen head word one clock in, then holds it for the rest of the stall
    padc_fifo #(
        .WIDTH(PADC_WORD_W),
        .DEPTH(PADC_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(st_r.word_valid),
        .in_ready(fifo_in_ready),
        .in_data(st_r.word),
        .out_valid(fifo_out_valid),
        .out_ready(out_ready),
        .out_data(fifo_out_data)
    );

    assign sample_phase = st_r.sample_phase;
    assign hold_phase = st_r.hold_phase;
    assign stage_amp = st_r.amp;
    assign out_word = st_r.out_word;
    assign out_bit_lsb = st_r.out_word[0]; // [R14]
    assign out_bit_one = st_r.out_word[1];
    assign out_bit_two = st_r.out_word[2];
    assign out_valid = st_r.out_valid;
endmodule

//--- hdl/padc_pkg.sv
package padc_pkg;
    localparam int PADC_STAGES = 4;
    localparam int PADC_STAGE_W = 4;
    localparam int PADC_WORD_W = 12;
    localparam int PADC_GAIN_SHIFT = 3;
    localparam int PADC_LATENCY = 3;
    localparam int PADC_FIFO_DEPTH = 4;
    localparam logic [3:0] PADC_CODE_MID = 4'h8;
    localparam logic [11:0] PADC_WORD_ZERO = 12'h000;
    localparam logic [11:0] PADC_WORD_ONES = 12'hfff;
    localparam logic [1:0] PADC_LAT_CNT_W0 = 2'h0;
    typedef enum logic [1:0] {PADC_FILL, PADC_RUN} padc_state_t;
endpackage

//--- hdl/padc_fifo.sv
`timescale 1ns/1ps
module padc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
        logic [WIDTH-1:0] dout;
        logic dvalid;
    } padc_fifo_st_t;
    logic [WIDTH-1:0] mem_r [DEPTH];
    padc_fifo_st_t st_r, st_nxt;
    logic [AW:0] count;
    logic push, pop, full, empty, load;
    assign count = st_r.wr - st_r.rd;
    assign full = count == (AW+1)'(DEPTH);
    assign empty = count == '0;
    assign in_ready = !full;
    assign push = in_valid && !full;
    // Registered read port: head word moves into dout when it is free
    assign load = !empty && (!st_r.dvalid || out_ready);
    assign pop = load;
    assign out_valid = st_r.dvalid;
    assign out_data = st_r.dout;
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wr = st_r.wr + 1'b1;
        end
        if (pop) begin
            st_nxt.rd = st_r.rd + 1'b1;
            st_nxt.dout = mem_r[st_r.rd[AW-1:0]];
            st_nxt.dvalid = 1'b1;
        end else if (out_ready) begin
            st_nxt.dvalid = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[st_r.wr[AW-1:0]] <= in_data;
        end
    end
endmodule

//--- sim/padc_core_sva.sv
`timescale 1ns/1ps
module padc_core_sva
    import padc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic out_ready,
    input wire logic sample_phase,
    input wire logic hold_phase,
    input wire logic [padc_pkg::PADC_WORD_W-1:0] out_word,
    input wire logic out_bit_lsb,
    input wire logic out_bit_one,
    input wire logic out_bit_two,
    input wire logic out_valid,
    input wire logic [padc_pkg::PADC_STAGES-1:0] stage_amp
);
    import padc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_NOVERLAP: assert property (!(sample_phase && hold_phase))
        else $error("phases overlap");
    AST_HOLD_NEXT: assert property (sample_phase |=> hold_phase)
        else $error("hold phase missing after sample");
    AST_GAP: assert property (hold_phase |=> !sample_phase && !hold_phase)
        else $error("no gap after hold");
    AST_RING: assert property (sample_phase |-> ##3 sample_phase)
        else $error("sample phase period wrong");
    AST_BITS: assert property ({out_bit_two, out_bit_one, out_bit_lsb} == out_word[2:0])
        else $error("low output bits wrong");
    AST_ALT: assert property ($past(reset_n, 2) |-> (stage_amp[2:0] ^ stage_amp[3:1]) == 3'h7)
        else $error("stage clocks not alternating");
    AST_STREAM: assert property (out_ready [*4] ##0 out_valid |=> out_valid)
        else $error("stream gap");
    AST_LATENCY: assert property ($rose(reset_n) |-> !out_valid [*3] ##[1:8] out_valid)
        else $error("first word latency wrong");
endmodule
bind padc_core padc_core_sva u_sva (.clk(clk), .reset_n(reset_n), .out_ready(out_ready),
    .sample_phase(sample_phase), .hold_phase(hold_phase), .out_word(out_word),
    .out_bit_lsb(out_bit_lsb), .out_bit_one(out_bit_one), .out_bit_two(out_bit_two),
    .out_valid(out_valid), .stage_amp(stage_amp));

//--- sim/padc_sink.sv
`timescale 1ns/1ps
module padc_sink (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [11:0] out_word,
    output logic out_ready,
    output int n_words,
    output logic [11:0] last_word
);
    // Combinational so a stall change lands off the sampling edge
    assign out_ready = !stall;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            n_words <= 0;
            last_word <= 12'h000;
        end else if (out_valid && out_ready) begin
            n_words <= n_words + 1;
            if (n_words >= 3) last_word <= out_word;
        end
    end
endmodule

//--- sim/pipeline_adc_output_path_tb.sv
`timescale 1ns/1ps
module pipeline_adc_output_path_tb;
    import padc_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic stall = 1'b0;
    logic [11:0] analog_code = 12'h000;
    logic out_ready, sample_phase, hold_phase, out_valid;
    logic out_bit_lsb, out_bit_one, out_bit_two;
    logic [11:0] out_word, last_word, w;
    logic [3:0] stage_amp;
    int n_words, mismatches = 0, n_tests = 0, c, n0;
    always #2.5 clk = ~clk;
    padc_core DUT (.clk(clk), .reset_n(reset_n), .analog_code(analog_code),
        .out_ready(out_ready), .sample_phase(sample_phase), .hold_phase(hold_phase),
        .out_word(out_word), .out_bit_lsb(out_bit_lsb), .out_bit_one(out_bit_one),
        .out_bit_two(out_bit_two), .out_valid(out_valid), .stage_amp(stage_amp));
    padc_sink u_sink (.clk(clk), .reset_n(reset_n), .stall(stall), .out_valid(out_valid),
        .out_word(out_word), .out_ready(out_ready), .n_words(n_words), .last_word(last_word));
    task chk(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task test_phases;
        c = 0;
        repeat (30) begin
            @(negedge clk);
            c += int'(sample_phase === 1'b1);
        end
        chk(12'(c), 12'h00a);
        $display("test_phases done");
    endtask
    task test_level(input logic [11:0] code);
        @(negedge clk);
        analog_code = code;
        repeat (20) @(negedge clk);
        chk(last_word, code);
        $display("test_level %h done", code);
    endtask
    task test_stream;
        n0 = n_words;
        repeat (10) @(negedge clk);
        chk(12'(n_words - n0), 12'h00a);
        $display("test_stream done");
    endtask
    task test_stall;
        // Long stall overflows the fifo; dropped words are not expected back
        stall = 1'b1;
        repeat (6) @(negedge clk);
        w = out_word;
        repeat (10) @(negedge clk);
        chk(out_word, w);
        n0 = n_words;
        stall = 1'b0;
        repeat (10) @(negedge clk);
        chk(12'(n_words - n0 > 7), 12'h001);
        $display("test_stall done");
    endtask
    initial begin
        #(20000 * 5);
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        test_phases();
        test_level(PADC_WORD_ONES);
        test_level(PADC_WORD_ZERO);
        test_level(12'h800);
        test_stream();
        test_stall();
        stop_test();
    end
endmodule
